// ### tb/host_bus_model.sv
// host processor bus model driving the port pins
`timescale 1ns/1ps

module host_bus_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] busWire,
   output logic            chipSelectN,
   output logic            readStrobe,
   output logic            writeStrobeN,
   output logic            addressLatchStrobe,
   output logic [6:0]      lowAddressLines,
   output logic [7:0]      hostData,
   output logic            hostDrive
);
   initial begin
      chipSelectN = 1'b1;
      readStrobe = 1'b1;
      writeStrobeN = 1'b1;
      addressLatchStrobe = 1'b0;
      lowAddressLines = 7'h00;
      hostData = 8'h00;
      hostDrive = 1'b0;
   end

   // one whole access; rd is the wire level while the strobe is active
   task automatic access(input logic bus_multiplex_select, style, wr, sel, input logic [7:0] addr, data,
                         output logic [7:0] rd);
      logic act;
      act = style & ~bus_multiplex_select;
      @(posedge clk_sys);
      readStrobe <= ~act;
      writeStrobeN <= 1'b1;
      lowAddressLines <= bus_multiplex_select ? 7'h00 : addr[6:0];
      addressLatchStrobe <= bus_multiplex_select ? 1'b0 : addr[7];
      if (bus_multiplex_select) begin
         hostData <= addr;
         hostDrive <= 1'b1;
         repeat (3) @(posedge clk_sys);
         addressLatchStrobe <= 1'b1;
         repeat (4) @(posedge clk_sys);
         addressLatchStrobe <= 1'b0;
      end
      hostData <= data;
      hostDrive <= wr;
      repeat (3) @(posedge clk_sys);
      chipSelectN <= ~sel;
      writeStrobeN <= ~wr;
      readStrobe <= (style | ~wr) ? act : ~act;
      repeat (8) @(posedge clk_sys);
      rd = busWire;
      readStrobe <= ~act;
      writeStrobeN <= 1'b1;
      chipSelectN <= 1'b1;
      repeat (4) @(posedge clk_sys);
      hostDrive <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : access
endmodule : host_bus_model

// ### tb/testbench.sv
// self-checking bench for the parallel host port
`timescale 1ns/1ps

module testbench;
   typedef struct packed {
      logic       wr;
      logic [7:0] a;
      logic [7:0] d;
   } note_s;

   logic        clk_sys;
   logic        sys_rst;
   logic        testPin;
   logic        busMultiplexSelect;
   logic        busStyleSelect;
   logic        chipSelectN;
   logic        readStrobe;
   logic        writeStrobeN;
   logic        addressLatchStrobe;
   logic [6:0]  lowAddressLines;
   logic [7:0]  hostData;
   logic        hostDrive;
   logic [7:0]  busWire;
   logic [7:0]  sharedDataLinesOut;
   logic        sharedDataLinesOeN;
   logic        intPinOut;
   logic        intPinOeN;
   logic [7:0]  regAddr;
   logic [7:0]  regWrData;
   logic        regWrStrobe;
   logic        regRdStrobe;
   logic [7:0]  regRdData;
   logic [23:0] statusFlags;
   logic [23:0] statusMask;
   note_s       notes[$];
   int          err_total;
   int          check_count;

   // undriven lines show the inverse of the host's last byte
   assign busWire = !sharedDataLinesOeN ? sharedDataLinesOut : hostDrive ? hostData : ~hostData;
   assign regRdData = regAddr ^ 8'h5a;

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   parallel_host_bus_port u_parallel_host_bus_port (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .testPin(testPin),
      .busMultiplexSelect(busMultiplexSelect), .busStyleSelect(busStyleSelect),
      .chipSelectN(chipSelectN), .readStrobe(readStrobe), .writeStrobeN(writeStrobeN),
      .addressLatchStrobe(addressLatchStrobe), .lowAddressLines(lowAddressLines),
      .sharedDataLinesIn(busWire), .sharedDataLinesOut(sharedDataLinesOut),
      .sharedDataLinesOeN(sharedDataLinesOeN), .intPinOut(intPinOut), .intPinOeN(intPinOeN),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
      .regRdStrobe(regRdStrobe), .regRdData(regRdData), .statusFlags(statusFlags),
      .statusMask(statusMask)
   );

   host_bus_model u_host_bus_model (
      .clk_sys(clk_sys), .busWire(busWire), .chipSelectN(chipSelectN),
      .readStrobe(readStrobe), .writeStrobeN(writeStrobeN),
      .addressLatchStrobe(addressLatchStrobe), .lowAddressLines(lowAddressLines),
      .hostData(hostData), .hostDrive(hostDrive)
   );

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // core-side watcher: each internal strobe takes the oldest note, looked at mid-cycle
   always @(negedge clk_sys) begin
      if (regWrStrobe === 1'b1 || regRdStrobe === 1'b1) begin
         if (notes.size() == 0) begin
            err_total++;
            $display("BAD %0t access seen with none expected", $time);
         end else begin
            note_s n;
            n = notes.pop_front();
            chk({7'h00, regWrStrobe}, {7'h00, n.wr});
            chk(regAddr, n.a);
            if (n.wr) chk(regWrData, n.d);
         end
      end
   end

   task automatic rw(input logic bus_multiplex_select, style, wr, sel, tst, input logic [7:0] a, d);
      logic [7:0] rd;
      if (sel) notes.push_back('{wr, a, d});
      u_host_bus_model.access(bus_multiplex_select, style, wr, sel, a, d, rd);
      if (!wr) chk(rd, (tst | ~sel) ? ~d : a ^ 8'h5a);
      chk({7'h00, sharedDataLinesOeN}, 8'h01);
   endtask : rw

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      logic [31:0] r;
      logic [31:0] s;
      logic        e;
      err_total = 0;
      check_count = 0;
      sys_rst = 1'b1;
      testPin = 1'b0;
      busMultiplexSelect = 1'b0;
      busStyleSelect = 1'b0;
      statusFlags = 24'h000000;
      statusMask = 24'h000000;
      void'($urandom(14360));
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys);
         busMultiplexSelect <= m[1];
         busStyleSelect <= m[0];
         repeat (4) @(posedge clk_sys);
         for (int k = 0; k < 3; k++) begin
            r = $urandom;
            rw(m[1], m[0], 1'b1, 1'b1, 1'b0, r[7:0], r[15:8]);
            rw(m[1], m[0], 1'b0, 1'b1, 1'b0, r[7:0], r[15:8]);
         end
         r = $urandom;
         rw(m[1], m[0], 1'b1, 1'b0, 1'b0, r[7:0], r[15:8]);
         rw(m[1], m[0], 1'b0, 1'b0, 1'b0, r[7:0], r[15:8]);
         $display("test bus mode %0d done", m);
      end
      @(posedge clk_sys);
      testPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      r = $urandom;
      rw(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, r[7:0], r[15:8]);
      rw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, r[7:0], r[15:8]);
      @(posedge clk_sys);
      testPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      $display("test float done");
      for (int i = 0; i < 10; i++) begin
         r = $urandom;
         s = (i < 2) ? 32'h0 : $urandom;
         e = (i == 9) | ~|(r[23:0] & s[23:0]);
         @(posedge clk_sys);
         statusFlags <= r[23:0];
         statusMask <= s[23:0];
         testPin <= (i == 9);
         repeat (4) @(posedge clk_sys);
         chk({7'h00, intPinOeN}, {7'h00, e});
         chk({7'h00, intPinOut}, 8'h00);
      end
      $display("test interrupt done");
      chk((notes.size() == 0) ? 8'h00 : 8'h01, 8'h00);
      close_out();
   end
endmodule : testbench

// ### verilog/host_pin_sync.sv
// two-stage synchroniser for the port pins
`timescale 1ns/1ps
`include "parallel_host_bus_port_defines.svh"

module host_pin_sync (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire logic [`PHP_SYNC_W-1:0] pinsAsync,
   output logic      [`PHP_SYNC_W-1:0] pinsSync
);
   localparam logic [`PHP_SYNC_W-1:0] RST_VAL = `PHP_SYNC_RST;

   logic [`PHP_SYNC_W-1:0] stage1_q;
   logic [`PHP_SYNC_W-1:0] stage2_q;

   for (genvar i = 0; i < `PHP_SYNC_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            stage1_q[i] <= RST_VAL[i];
            stage2_q[i] <= RST_VAL[i];
         end else begin
            stage1_q[i] <= pinsAsync[i];
            stage2_q[i] <= stage1_q[i];
         end
      end
   end

   assign pinsSync = stage2_q;
endmodule : host_pin_sync

// ### verilog/host_port_pkg.sv
// types shared by the parallel host port
package host_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } access_state_e;

   typedef logic [7:0] port_byte_t;
endpackage : host_port_pkg

// ### verilog/host_strobe_decode.sv
// turns strobe pins into read and write requests per bus style
`timescale 1ns/1ps

module host_strobe_decode (
   input  wire logic multiplexed,
   input  wire logic styleStrobe,
   input  wire logic chipSelectN,
   input  wire logic readLevel,
   input  wire logic writeLevel,
   output logic      readReq,
   output logic      writeReq
);
   function automatic logic levelOn(input logic level, input logic activeHigh);
      levelOn = activeHigh ? level : !level;
   endfunction : levelOn

   logic selected;
   logic readOn;
   logic writeOn;

   assign selected = !chipSelectN;
   // data strobe is active high only with separate address lines
   assign readOn   = levelOn(readLevel, styleStrobe && !multiplexed);
   assign writeOn  = levelOn(writeLevel, 1'b0);

   always_comb begin
      if (styleStrobe) begin
         readReq  = selected && readOn && !writeOn;
         writeReq = selected && readOn && writeOn;
      end else begin
         // both strobes at once is refused
         readReq  = selected && readOn && !writeOn;
         writeReq = selected && writeOn && !readOn;
      end
   end
endmodule : host_strobe_decode

// ### verilog/parallel_host_bus_port.sv
// device-side parallel host port: pin capture, access sequencing, interrupt pin
`timescale 1ns/1ps
`include "parallel_host_bus_port_defines.svh"

module parallel_host_bus_port (
   input  wire logic                     clk_sys,
   input  wire logic                     sys_rst,
   input  wire logic                     testPin,
   input  wire logic                     busMultiplexSelect,
   input  wire logic                     busStyleSelect,
   input  wire logic                     chipSelectN,
   input  wire logic                     readStrobe,
   input  wire logic                     writeStrobeN,
   input  wire logic                     addressLatchStrobe,
   input  wire logic [`PHP_LOW_W-1:0]    lowAddressLines,
   input  wire logic [`PHP_DATA_W-1:0]   sharedDataLinesIn,
   output logic      [`PHP_DATA_W-1:0]   sharedDataLinesOut,
   output logic                          sharedDataLinesOeN,
   output logic                          intPinOut,
   output logic                          intPinOeN,
   output logic      [`PHP_DATA_W-1:0]   regAddr,
   output logic      [`PHP_DATA_W-1:0]   regWrData,
   output logic                          regWrStrobe,
   output logic                          regRdStrobe,
   input  wire logic [`PHP_DATA_W-1:0]   regRdData,
   input  wire logic [`PHP_STATUS_W-1:0] statusFlags,
   input  wire logic [`PHP_STATUS_W-1:0] statusMask
);

   // synchronised pins
   logic [`PHP_SYNC_W-1:0] pinsSync;
   logic                   testS;
   logic                   multiS;
   logic                   styleS;
   logic                   csNS;
   logic                   readS;
   logic                   writeS;
   logic                   latchS;
   logic [`PHP_LOW_W-1:0]  lowS;
   logic [`PHP_DATA_W-1:0] dataS;

   // decoded requests
   logic readReq;
   logic writeReq;

   // access sequencing
   host_port_pkg::access_state_e state_q;
   host_port_pkg::access_state_e state_d;
   logic                         stIdle;
   logic                         stRead;
   logic                         stWrite;

   logic                   latchPrev_q;
   logic                   latchRise;
   logic [`PHP_DATA_W-1:0] latchedAddr_q;
   logic [`PHP_DATA_W-1:0] accessAddr;

   logic [`PHP_DATA_W-1:0] regAddr_q;
   logic [`PHP_DATA_W-1:0] regWrData_q;
   logic                   regWrStrobe_q;
   logic                   regRdStrobe_q;
   logic [`PHP_DATA_W-1:0] dataOut_q;
   logic                   dataOeN_q;
   logic                   intOut_q;
   logic                   intOeN_q;
   logic                   intPending;

   host_pin_sync u_sync (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .pinsAsync ({testPin,
                   busMultiplexSelect,
                   busStyleSelect,
                   chipSelectN,
                   readStrobe,
                   writeStrobeN,
                   addressLatchStrobe,
                   lowAddressLines,
                   sharedDataLinesIn}),
      .pinsSync  (pinsSync)
   );

   assign testS  = pinsSync[`PHP_SV_TEST];
   assign multiS = pinsSync[`PHP_SV_MULTI];
   assign styleS = pinsSync[`PHP_SV_STYLE];
   assign csNS   = pinsSync[`PHP_SV_CS];
   assign readS  = pinsSync[`PHP_SV_READ];
   assign writeS = pinsSync[`PHP_SV_WRITE];
   assign latchS = pinsSync[`PHP_SV_LATCH];
   assign lowS   = pinsSync[`PHP_SV_LOW_MSB:`PHP_SV_LOW_LSB];
   assign dataS  = pinsSync[`PHP_SV_DATA_MSB:`PHP_SV_DATA_LSB];

   host_strobe_decode u_decode (
      .multiplexed (multiS),
      .styleStrobe (styleS),
      .chipSelectN (csNS),
      .readLevel   (readS),
      .writeLevel  (writeS),
      .readReq     (readReq),
      .writeReq    (writeReq)
   );

   assign stIdle  = (state_q == host_port_pkg::ST_IDLE);
   assign stRead  = (state_q == host_port_pkg::ST_READ);
   assign stWrite = (state_q == host_port_pkg::ST_WRITE);

   // address demultiplexing
   assign latchRise = latchS && !latchPrev_q;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         latchPrev_q <= 1'b0;
      end else begin
         latchPrev_q <= latchS;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         latchedAddr_q <= `PHP_DATA_RST;
      end else if (multiS && latchRise) begin
         latchedAddr_q <= dataS;
      end
   end

   // low address lines play no part when multiplexed
   always_comb begin
      if (multiS) begin
         accessAddr = latchedAddr_q;
      end else begin
         accessAddr = {latchS, lowS};
      end
   end

   // access state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         host_port_pkg::ST_IDLE: begin
            if (readReq) begin
               state_d = host_port_pkg::ST_READ;
            end else if (writeReq) begin
               state_d = host_port_pkg::ST_WRITE;
            end
         end
         host_port_pkg::ST_READ: begin
            if (!readReq) begin
               state_d = host_port_pkg::ST_IDLE;
            end
         end
         host_port_pkg::ST_WRITE: begin
            if (!writeReq) begin
               state_d = host_port_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = host_port_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= host_port_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // address for the core, taken at the start of an access
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regAddr_q <= `PHP_DATA_RST;
      end else if (stIdle && (readReq || writeReq)) begin
         regAddr_q <= accessAddr;
      end
   end

   // one-cycle read request to the core
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdStrobe_q <= 1'b0;
      end else begin
         regRdStrobe_q <= stIdle && readReq;
      end
   end

   // write data follows the bus until the strobe ends
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regWrData_q <= `PHP_DATA_RST;
      end else if (stWrite && writeReq) begin
         regWrData_q <= dataS;
      end
   end

   // commit on the trailing edge of the write
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regWrStrobe_q <= 1'b0;
      end else begin
         regWrStrobe_q <= stWrite && !writeReq;
      end
   end

   // read data drive, released outside a read or under test
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dataOut_q <= `PHP_DATA_RST;
         dataOeN_q <= `PHP_OEN_RST;
      end else begin
         if (stRead && readReq) begin
            dataOut_q <= regRdData;
         end
         dataOeN_q <= !(stRead && readReq) || testS;
      end
   end

   // open-drain interrupt
   assign intPending = |(statusFlags & statusMask);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         intOut_q <= `PHP_INT_LEVEL;
         intOeN_q <= `PHP_OEN_RST;
      end else begin
         intOut_q <= `PHP_INT_LEVEL;
         intOeN_q <= !intPending || testS;
      end
   end

   assign sharedDataLinesOut = dataOut_q;
   assign sharedDataLinesOeN = dataOeN_q;
   assign intPinOut          = intOut_q;
   assign intPinOeN          = intOeN_q;
   assign regAddr            = regAddr_q;
   assign regWrData          = regWrData_q;
   assign regWrStrobe        = regWrStrobe_q;
   assign regRdStrobe        = regRdStrobe_q;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence readStart;
      stIdle && readReq;
   endsequence

   sequence writeEnd;
      stWrite && writeReq ##1 !writeReq;
   endsequence

   chk_sep_address: assert property (
      readStart and !multiS |=> regAddr_q == $past({latchS, lowS}))
      else $error("separate address not taken from low lines and latch");

   chk_shared_address: assert property (
      readStart and multiS |=> regAddr_q == $past(latchedAddr_q))
      else $error("shared address not taken from latched byte");

   chk_latch_edge: assert property (
      multiS && latchS && !latchPrev_q |=> latchedAddr_q == $past(dataS))
      else $error("address not captured on latch rising edge");

   chk_latch_hold: assert property (
      !(latchS && !latchPrev_q) |=> $stable(latchedAddr_q))
      else $error("latched address changed without a rising edge");

   chk_strobe_style: assert property (
      stIdle && !csNS && !styleS && !readS && writeS |=> regRdStrobe_q)
      else $error("read strobe style not recognised");

   chk_data_strobe: assert property (
      stIdle && !csNS && styleS && writeS && (readS ^ multiS) |=> regRdStrobe_q)
      else $error("data strobe polarity not honoured");

   chk_deselect: assert property (
      stIdle && csNS |=> !regRdStrobe_q ##1 !regWrStrobe_q)
      else $error("access answered while deselected");

   chk_write_commit: assert property (
      writeEnd |=> regWrStrobe_q && regWrData_q == $past(dataS, 2))
      else $error("write not committed with last data");

   chk_write_single: assert property (
      regWrStrobe_q |=> !regWrStrobe_q)
      else $error("write commit longer than one cycle");

   chk_read_drive: assert property (
      stRead && readReq && !testS |=> !dataOeN_q && dataOut_q == $past(regRdData))
      else $error("read data not driven");

   chk_drive_only_read: assert property (
      !dataOeN_q |-> $past(stRead) && $past(readReq))
      else $error("data lines driven outside a read");

   chk_int_assert: assert property (
      intPending && !testS |=> !intOeN_q && intOut_q == 1'b0)
      else $error("interrupt not pulled low");

   chk_int_release: assert property (
      !intPending |=> intOeN_q)
      else $error("interrupt held without a condition");

   chk_test_float: assert property (
      testS |=> dataOeN_q && intOeN_q)
      else $error("outputs driven under tri-state control");

endmodule : parallel_host_bus_port

// ### verilog/parallel_host_bus_port_defines.svh
// constants for the device-side parallel host port
`ifndef PARALLEL_HOST_BUS_PORT_DEFINES_SVH
`define PARALLEL_HOST_BUS_PORT_DEFINES_SVH

`define PHP_DATA_W      8
`define PHP_LOW_W       7
`define PHP_STATUS_W    24
`define PHP_SYNC_W      22

// positions inside the synchronised pin vector
`define PHP_SV_DATA_LSB 0
`define PHP_SV_DATA_MSB 7
`define PHP_SV_LOW_LSB  8
`define PHP_SV_LOW_MSB  14
`define PHP_SV_LATCH    15
`define PHP_SV_WRITE    16
`define PHP_SV_READ     17
`define PHP_SV_CS       18
`define PHP_SV_STYLE    19
`define PHP_SV_MULTI    20
`define PHP_SV_TEST     21

// read and write strobes and select idle high after reset, address latch strobe low
`define PHP_SYNC_RST    22'h070000
`define PHP_DATA_RST    8'h00
`define PHP_OEN_RST     1'b1
`define PHP_INT_LEVEL   1'b0

`endif
